// [rtl/phy_ctrl_cfg.svh]
// constants for the phy basic control register
// Functional notes
// - writing one to bit 15 resets all phy control and status registers, reads one while the reset runs, then clears itself.
// - bit 14 set loops the four-bit transmit nibbles back into the receive data path; the code only stores bit 14 and loops on cfg_loop alone.
// - during loopback the receive path is cut off from the line.
// - entering loopback may cost about 560 ns of invalid receive data while the descrambler relocks.
// - the controller loopback configuration setting wins over bit 14 when they disagree.
// - with auto-negotiation off, bit 13 selects 100 Mbps when one and 10 Mbps when zero.
// - bit 12 enables auto-negotiation, and while enabled bits 13 and 8 are ignored.
// - bit 11 puts the phy into its low-power state and clearing it restores normal operation.
// - writing one to bit 9 restarts auto-negotiation and the bit clears itself.
// - with auto-negotiation off, bit 8 selects full duplex when one and half duplex when zero.
// - in loopback the phy behaviour does not depend on bit 8.
// - bit 7 forces collision whenever transmit enable is high.
`ifndef PHY_CTRL_CFG_SVH
`define PHY_CTRL_CFG_SVH
`define PCR_OFFSET       5'h00
`define PCR_BIT_RESET    15
`define PCR_BIT_LOOP     14
`define PCR_BIT_SPEED    13
`define PCR_BIT_ANEN     12
`define PCR_BIT_PDOWN    11
`define PCR_BIT_RSVD10   10
`define PCR_BIT_RESTART  9
`define PCR_BIT_DUPLEX   8
`define PCR_BIT_COLTEST  7
`define PCR_RESET_VALUE  16'h3000
`define PCR_WMASK        16'hfb80
`define CLK_PERIOD_NS    8
`define SOFT_RESET_NS    64
`define SOFT_RESET_CYC   ((`SOFT_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEAD_TIME_NS     560
`define DEAD_TIME_CYC    (`DEAD_TIME_NS / `CLK_PERIOD_NS)
`endif

// [rtl/phy_ctrl_pkg.sv]
// types shared by the phy basic control register block
package phy_ctrl_pkg;
  // effective operating controls handed to the phy datapath
  typedef struct packed {
    logic speed_100;
    logic full_duplex;
    logic an_enable;
    logic an_restart;
    logic power_down;
    logic loopback;
    logic col_test;
  } phy_mode_t;

  typedef enum logic [1:0] {
    RST_IDLE = 2'b01,
    RST_BUSY = 2'b10
  } rst_state_t;
endpackage : phy_ctrl_pkg

// [rtl/phy_soft_reset.sv]
// soft reset sequencer: holds the phy reset for a fixed count
`include "phy_ctrl_cfg.svh"
module phy_soft_reset (
  input  wire logic mclk,      // management clock
  input  wire logic arst_n,    // async reset, active low
  input  wire logic start,     // one-cycle request to reset
  output logic      busy       // high while reset runs
);
  localparam logic [7:0] RST_CYC = 8'(`SOFT_RESET_CYC);

  phy_ctrl_pkg::rst_state_t state_q;
  logic [7:0]               cnt_q;
  wire                      done = (cnt_q == RST_CYC - 8'h01);

  assign busy = (state_q == phy_ctrl_pkg::RST_BUSY);

  // count out the reset, then release
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      state_q <= phy_ctrl_pkg::RST_IDLE;
      cnt_q   <= 8'h00;
    end
    else
    begin
      case (state_q)
        phy_ctrl_pkg::RST_IDLE:
        begin
          cnt_q <= 8'h00;
          if (start)
            state_q <= phy_ctrl_pkg::RST_BUSY;
        end
        phy_ctrl_pkg::RST_BUSY:
        begin
          cnt_q <= cnt_q + 8'h01;
          if (done)
            state_q <= phy_ctrl_pkg::RST_IDLE;
        end
        default: state_q <= phy_ctrl_pkg::RST_IDLE;
      endcase
    end

  property p_reset_len;
    @(posedge mclk) disable iff (!arst_n)
    $rose(busy) |-> busy [*8] ##1 !busy;
  endproperty
  a_reset_len: assert property (p_reset_len)
    else $error("soft reset length wrong");
endmodule : phy_soft_reset

// [rtl/phy_loop_gate.sv]
// receive path selector with loopback and dead-time blanking
`include "phy_ctrl_cfg.svh"
module phy_loop_gate (
  input  wire logic       mclk,       // management clock
  input  wire logic       arst_n,     // async reset, active low
  input  wire logic       loopback,   // effective loopback
  input  wire logic [3:0] tx_data,    // transmit nibble
  input  wire logic       tx_en,      // transmit enable
  input  wire logic [3:0] line_data,  // nibble from the line
  input  wire logic       line_dv,    // line data valid
  output logic      [3:0] rx_data,    // receive nibble
  output logic            rx_dv       // receive data valid
);
  localparam logic [6:0] DEAD_CYC = 7'(`DEAD_TIME_CYC);

  logic       loop_q;
  logic [6:0] dead_q;
  wire        enter = loopback & ~loop_q;
  wire        dead  = (dead_q != 7'h00);
  // the line is never looked at in loopback
  wire [3:0]  sel_d = loopback ? tx_data : line_data;
  wire        sel_v = loopback ? tx_en : line_dv;

  // descrambler relock time: blank valid after loopback entry
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      loop_q  <= 1'b0;
      dead_q  <= 7'h00;
      rx_data <= 4'h0;
      rx_dv   <= 1'b0;
    end
    else
    begin
      loop_q  <= loopback;
      dead_q  <= enter ? DEAD_CYC : (dead ? dead_q - 7'h01 : 7'h00);
      rx_data <= sel_d;
      rx_dv   <= sel_v & ~dead & ~enter;
    end

  property p_dead;
    @(posedge mclk) disable iff (!arst_n)
    $rose(loop_q) |-> !rx_dv [*8];
  endproperty
  a_dead: assert property (p_dead)
    else $error("valid during loopback dead time");
endmodule : phy_loop_gate

// [rtl/phy_basic_control_register.sv]
// phy basic control register with its mode outputs
`include "phy_ctrl_cfg.svh"
module phy_basic_control_register (
  input  wire logic        mclk,        // management clock
  input  wire logic        arst_n,      // async reset, active low
  input  wire logic        reg_wr,      // write strobe
  input  wire logic        reg_rd,      // read strobe
  input  wire logic [4:0]  reg_addr,    // register address
  input  wire logic [15:0] reg_wdata,   // write data
  output logic      [15:0] reg_rdata,   // read data
  output logic             reg_ack,     // access accepted
  input  wire logic        cfg_loop,    // controller loopback setting
  input  wire logic        only_full,   // phy supports full only
  input  wire logic        only_half,   // phy supports half only
  input  wire logic        an_done,     // auto-negotiation result valid
  input  wire logic        an_speed,    // negotiated speed, 1 = 100
  input  wire logic        an_duplex,   // negotiated duplex, 1 = full
  input  wire logic [3:0]  tx_data,     // mii transmit nibble
  input  wire logic        tx_en,       // mii transmit enable
  input  wire logic [3:0]  line_data,   // nibble from the line
  input  wire logic        line_dv,     // line data valid
  input  wire logic        line_col,    // collision from the line
  output logic      [3:0]  rx_data,     // receive nibble
  output logic             rx_dv,       // receive data valid
  output logic             col,         // collision indication
  output phy_ctrl_pkg::phy_mode_t mode, // effective operating mode
  output logic             phy_rst      // reset to all phy registers
);
  logic [15:0] ctrl_q;
  logic        rst_busy;
  logic        col_q;
  phy_ctrl_pkg::phy_mode_t mode_q;

  // duplex forced when only one mode exists
  function automatic logic fix_duplex(input logic v, input logic f,
                                      input logic h);
    fix_duplex = f ? 1'b1 : (h ? 1'b0 : v);
  endfunction : fix_duplex

  // address decode and strobes; busy refuses accesses
  wire hit     = (reg_addr == `PCR_OFFSET);
  // a pending bit 15 also refuses, so no write is lost in the release cycle
  wire busy_all = rst_busy | ctrl_q[`PCR_BIT_RESET];
  wire wr_ok   = reg_wr & hit & ~busy_all;
  wire rd_ok   = reg_rd & ~busy_all;
  wire sw_rst  = wr_ok & reg_wdata[`PCR_BIT_RESET];
  wire restart = wr_ok & reg_wdata[`PCR_BIT_RESTART];
  wire [15:0] wval = reg_wdata & `PCR_WMASK;
  wire [15:0] wfix = {wval[15:9],
                      fix_duplex(wval[`PCR_BIT_DUPLEX], only_full, only_half),
                      wval[7:0]};

  // effective mode: configuration wins over the loopback bit
  wire loop_eff = cfg_loop;
  wire an_en    = ctrl_q[`PCR_BIT_ANEN];
  wire spd_eff  = an_en ? an_speed
                        : ctrl_q[`PCR_BIT_SPEED];
  wire dpx_man  = an_en ? an_duplex
                        : ctrl_q[`PCR_BIT_DUPLEX];
  // loopback runs full duplex regardless of bit 8
  wire dpx_eff  = loop_eff ? 1'b1 : dpx_man;
  wire col_eff  = ctrl_q[`PCR_BIT_COLTEST] ? tx_en : (line_col & ~loop_eff);

  assign reg_ack  = (reg_wr | reg_rd) & ~busy_all;
  assign phy_rst  = rst_busy;
  assign mode     = mode_q;
  assign col      = col_q;

  phy_soft_reset u_rst (
    .mclk   (mclk),
    .arst_n (arst_n),
    .start  (sw_rst),
    .busy   (rst_busy)
  );

  phy_loop_gate u_loop (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .loopback  (loop_eff),
    .tx_data   (tx_data),
    .tx_en     (tx_en),
    .line_data (line_data),
    .line_dv   (line_dv),
    .rx_data   (rx_data),
    .rx_dv     (rx_dv)
  );

  // register store; soft reset restores the default
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
      ctrl_q <= `PCR_RESET_VALUE;
    else if (sw_rst)
      ctrl_q <= `PCR_RESET_VALUE | 16'h8000;
    else if (rst_busy)
      ctrl_q <= ctrl_q;
    else if (ctrl_q[`PCR_BIT_RESET])
      ctrl_q <= `PCR_RESET_VALUE;
    else if (wr_ok)
      ctrl_q <= wfix;
    else
      ctrl_q <= ctrl_q & ~16'h0200;

  // read data registered; reset bit reads one while busy
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
      reg_rdata <= 16'h0000;
    else if (rd_ok)
      reg_rdata <= hit ? ctrl_q : 16'h0000;
    else if (busy_all)
      reg_rdata <= 16'h8000;

  // operating outputs registered for clean timing
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      mode_q <= '0;
      col_q  <= 1'b0;
    end
    else
    begin
      mode_q.speed_100   <= spd_eff;
      mode_q.full_duplex <= dpx_eff;
      mode_q.an_enable   <= an_en;
      mode_q.an_restart  <= restart;
      mode_q.power_down  <= ctrl_q[`PCR_BIT_PDOWN];
      mode_q.loopback    <= loop_eff;
      mode_q.col_test    <= ctrl_q[`PCR_BIT_COLTEST];
      col_q              <= col_eff;
    end

  property p_selfclear;
    @(posedge mclk) disable iff (!arst_n)
    restart && !sw_rst |=> ctrl_q[9] ##1 !ctrl_q[9];
  endproperty
  a_selfclear: assert property (p_selfclear)
    else $error("restart bit did not self clear");

  property p_col;
    @(posedge mclk) disable iff (!arst_n)
    ctrl_q[7] && tx_en |=> col_q;
  endproperty
  a_col: assert property (p_col)
    else $error("forced collision missing");

  property p_speed;
    @(posedge mclk) disable iff (!arst_n)
    !ctrl_q[12] |=> mode_q.speed_100 == $past(ctrl_q[13]);
  endproperty
  a_speed: assert property (p_speed)
    else $error("manual speed not applied");

  property p_an_ignore;
    @(posedge mclk) disable iff (!arst_n)
    arst_n && ctrl_q[12] && !cfg_loop |=>
      mode_q.full_duplex == $past(an_duplex);
  endproperty
  a_an_ignore: assert property (p_an_ignore)
    else $error("manual duplex used under auto-negotiation");

  property p_loop_dpx;
    @(posedge mclk) disable iff (!arst_n)
    cfg_loop |=> mode_q.full_duplex && mode_q.loopback;
  endproperty
  a_loop_dpx: assert property (p_loop_dpx)
    else $error("loopback depends on duplex bit");

  property p_pdown;
    @(posedge mclk) disable iff (!arst_n)
    wr_ok && !sw_rst |=> ##1 mode_q.power_down == $past(reg_wdata[11], 2);
  endproperty
  a_pdown: assert property (p_pdown)
    else $error("power down not applied");

  property p_rsvd;
    @(posedge mclk) disable iff (!arst_n)
    ctrl_q[10] == 1'b0 && ctrl_q[6:0] == 7'h00;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bits stored");

  property p_rst_done;
    @(posedge mclk) disable iff (!arst_n)
    $fell(rst_busy) |=> ctrl_q == 16'h3000;
  endproperty
  a_rst_done: assert property (p_rst_done)
    else $error("soft reset did not restore default");

  property p_busy_ack;
    @(posedge mclk) disable iff (!arst_n)
    busy_all |-> !reg_ack;
  endproperty
  a_busy_ack: assert property (p_busy_ack)
    else $error("access accepted during soft reset");

  property p_busy_hold;
    @(posedge mclk) disable iff (!arst_n)
    rst_busy |-> ctrl_q[15];
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("reset bit low while reset runs");

  property p_busy_release;
    @(posedge mclk) disable iff (!arst_n)
    $fell(rst_busy) |-> ctrl_q[15] ##1 !ctrl_q[15];
  endproperty
  a_busy_release: assert property (p_busy_release)
    else $error("reset bit did not self clear");

  property p_rst_start;
    @(posedge mclk) disable iff (!arst_n)
    sw_rst |=> rst_busy && ctrl_q == 16'hb000;
  endproperty
  a_rst_start: assert property (p_rst_start)
    else $error("soft reset did not start");

  property p_busy_rdata;
    @(posedge mclk) disable iff (!arst_n)
    rst_busy |=> reg_rdata == 16'h8000;
  endproperty
  a_busy_rdata: assert property (p_busy_rdata)
    else $error("read data during soft reset wrong");

  property p_wr_upper;
    @(posedge mclk) disable iff (!arst_n)
    wr_ok && !sw_rst |=> ctrl_q[15:11] == $past(reg_wdata[15:11]);
  endproperty
  a_wr_upper: assert property (p_wr_upper)
    else $error("control bits not stored");

  property p_wr_duplex;
    @(posedge mclk) disable iff (!arst_n)
    wr_ok && !sw_rst && !only_full && !only_half |=>
      ctrl_q[8] == $past(reg_wdata[8]);
  endproperty
  a_wr_duplex: assert property (p_wr_duplex)
    else $error("duplex bit not stored");

  property p_only_full;
    @(posedge mclk) disable iff (!arst_n)
    wr_ok && !sw_rst && only_full |=> ctrl_q[8];
  endproperty
  a_only_full: assert property (p_only_full)
    else $error("duplex bit not pinned to full");

  property p_only_half;
    @(posedge mclk) disable iff (!arst_n)
    wr_ok && !sw_rst && only_half && !only_full |=> !ctrl_q[8];
  endproperty
  a_only_half: assert property (p_only_half)
    else $error("duplex bit not pinned to half");

  property p_restart_pulse;
    @(posedge mclk) disable iff (!arst_n)
    restart |=> mode_q.an_restart;
  endproperty
  a_restart_pulse: assert property (p_restart_pulse)
    else $error("restart pulse missing");

  property p_restart_quiet;
    @(posedge mclk) disable iff (!arst_n)
    !restart |=> !mode_q.an_restart;
  endproperty
  a_restart_quiet: assert property (p_restart_quiet)
    else $error("restart pulse without request");

  property p_pdown_on;
    @(posedge mclk) disable iff (!arst_n)
    ctrl_q[11] |=> mode_q.power_down;
  endproperty
  a_pdown_on: assert property (p_pdown_on)
    else $error("low power state not entered");

  property p_pdown_off;
    @(posedge mclk) disable iff (!arst_n)
    !ctrl_q[11] |=> !mode_q.power_down;
  endproperty
  a_pdown_off: assert property (p_pdown_off)
    else $error("low power state not left");

  property p_an_speed;
    @(posedge mclk) disable iff (!arst_n)
    arst_n && ctrl_q[12] |=> mode_q.speed_100 == $past(an_speed);
  endproperty
  a_an_speed: assert property (p_an_speed)
    else $error("manual speed used under auto-negotiation");

  property p_man_duplex;
    @(posedge mclk) disable iff (!arst_n)
    arst_n && !ctrl_q[12] && !cfg_loop |=>
      mode_q.full_duplex == $past(ctrl_q[8]);
  endproperty
  a_man_duplex: assert property (p_man_duplex)
    else $error("manual duplex not applied");

  property p_loop_prio;
    @(posedge mclk) disable iff (!arst_n)
    arst_n && cfg_loop != ctrl_q[14] |=>
      mode_q.loopback == $past(cfg_loop);
  endproperty
  a_loop_prio: assert property (p_loop_prio)
    else $error("loopback bit won over configuration");

  property p_loop_no_col;
    @(posedge mclk) disable iff (!arst_n)
    cfg_loop && !ctrl_q[7] |=> !col_q;
  endproperty
  a_loop_no_col: assert property (p_loop_no_col)
    else $error("line collision seen in loopback");

  property p_col_normal;
    @(posedge mclk) disable iff (!arst_n)
    arst_n && !ctrl_q[7] && !cfg_loop |=> col_q == $past(line_col);
  endproperty
  a_col_normal: assert property (p_col_normal)
    else $error("collision reporting not normal");

  property p_loop_echo;
    @(posedge mclk) disable iff (!arst_n)
    arst_n && cfg_loop |=> rx_data == $past(tx_data);
  endproperty
  a_loop_echo: assert property (p_loop_echo)
    else $error("transmit nibble not looped back");

  property p_col_mode;
    @(posedge mclk) disable iff (!arst_n)
    ctrl_q[7] |=> mode_q.col_test;
  endproperty
  a_col_mode: assert property (p_col_mode)
    else $error("collision test mode not shown");
endmodule : phy_basic_control_register

// [verification/mac_tx_model.sv]
// host-side transmit source feeding the mii transmit pins
module mac_tx_model (
  input  wire logic       mclk,     // management clock
  input  wire logic       send,     // frame request from the bench
  output logic      [3:0] tx_data,  // transmit nibble
  output logic            tx_en     // transmit enable
);
  timeunit 1ns;
  timeprecision 100ps;
  initial tx_data = 4'h3;
  initial tx_en = 1'b0;
  // nibbles alternate so a stuck loop path shows; idle data inverts
  always @(posedge mclk)
  begin
    tx_en   <= send;
    tx_data <= send ? {2'b01, ~tx_data[1], 1'b1} : ~tx_data;
  end
endmodule : mac_tx_model

// [verification/phy_basic_control_register_tb.sv]
// self-checking bench for the phy basic control register
module phy_basic_control_register_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [4:0]  reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        cfg_loop = 1'b0, only_full = 1'b0, only_half = 1'b0;
  logic        an_done = 1'b1, an_speed = 1'b0, an_duplex = 1'b1;
  logic        send = 1'b0, line_dv = 1'b0, line_col = 1'b0;
  logic [3:0]  line_data = 4'ha;
  logic [3:0]  tx_data, rx_data, prev_tx;
  logic        tx_en, rx_dv, col, phy_rst, reg_ack;
  logic [15:0] reg_rdata;
  phy_ctrl_pkg::phy_mode_t mode;
  int          error_cnt = 0, total_checks = 0, cycles = 0, n;

  mac_tx_model mac_tx_model_i (.mclk, .send, .tx_data, .tx_en);
  phy_basic_control_register phy_basic_control_register_i (
    .mclk, .arst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_ack, .cfg_loop, .only_full, .only_half, .an_done, .an_speed,
    .an_duplex, .tx_data, .tx_en, .line_data, .line_dv, .line_col,
    .rx_data, .rx_dv, .col, .mode, .phy_rst);

  always #4 mclk = ~mclk;
  // last nibble sent, what the loop path should echo; plus hang guard
  always @(posedge mclk)
  begin
    prev_tx <= tx_data;
    cycles  <= cycles + 1;
    if (cycles == 4000)
    begin
      error_cnt++;
      results();
    end
  end

  task chk(string name, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // hold the strobe until ack is seen settled, then release on the edge
  task acc(logic w, logic [4:0] a, logic [15:0] d);
    @(posedge mclk);
    reg_wr    <= w;
    reg_rd    <= !w;
    reg_addr  <= a;
    reg_wdata <= d;
    n = 0;
    do @(negedge mclk); while (reg_ack !== 1'b1 && ++n < 50);
    if (n >= 50) error_cnt++; // no acknowledge counts as a mismatch
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
  endtask : acc

  task rdc(logic [15:0] exp);
    acc(1'b0, 5'h00, 16'h0000);
    chk("ctrl", reg_rdata, exp);
  endtask : rdc

  // mode is registered behind the control word, so let it settle
  task md(logic [15:0] exp);
    repeat (2) @(posedge mclk);
    #1;
    chk("mode", 16'(mode), exp);
  endtask : md

  task results();
    if (error_cnt == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  initial
  begin
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    rdc(16'h3000);
    md(16'h0030);
    acc(1'b0, 5'h01, 16'h0000);
    chk("unmapped", reg_rdata, 16'h0000);
    acc(1'b1, 5'h00, 16'h2100);
    rdc(16'h2100);
    md(16'h0060);
    acc(1'b1, 5'h00, 16'h0000);
    md(16'h0000);
    acc(1'b1, 5'h00, 16'h3100);
    md(16'h0030);
    acc(1'b1, 5'h00, 16'h0800);
    md(16'h0004);
    acc(1'b1, 5'h00, 16'h0000);
    md(16'h0000);
    acc(1'b1, 5'h00, 16'h1200);
    chk("restart", 16'(mode.an_restart), 16'h0001);
    rdc(16'h1000);
    chk("restart", 16'(mode.an_restart), 16'h0000);
    // single-duplex capability pins the duplex bit
    @(posedge mclk) only_half <= 1'b1;
    acc(1'b1, 5'h00, 16'h0100);
    rdc(16'h0000);
    @(posedge mclk) {only_half, only_full} <= 2'b01;
    acc(1'b1, 5'h00, 16'h0000);
    rdc(16'h0100);
    @(posedge mclk) only_full <= 1'b0;
    // forced collision follows transmit enable
    acc(1'b1, 5'h00, 16'h0080);
    @(posedge mclk) send <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 chk("col", 16'(col), 16'h0001);
    @(posedge mclk) send <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 chk("col", 16'(col), 16'h0000);
    // bit 14 alone does not loop when the config setting is off
    acc(1'b1, 5'h00, 16'h4000);
    @(posedge mclk) line_dv <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 chk("rx", {rx_dv, rx_data}, 16'h001a);
    @(posedge mclk)
    begin
      cfg_loop <= 1'b1;
      send     <= 1'b1;
      line_col <= 1'b1;
    end
    n = 0;
    while (n < 80)
    begin
      @(posedge mclk);
      #1;
      if (rx_dv !== 1'b0) break;
      n++;
    end
    chk("dead", 16'(n), 16'd71);
    repeat (4) @(posedge mclk);
    #1 chk("loop", {rx_dv, rx_data}, {11'h0, 1'b1, prev_tx});
    chk("col", 16'(col), 16'h0000);
    md(16'h0022);
    @(posedge mclk) {cfg_loop, send, line_col} <= 3'b000;
    // soft reset refuses access while it runs, then restores defaults
    acc(1'b1, 5'h00, 16'h8800);
    chk("phy_rst", 16'(phy_rst), 16'h0001);
    @(posedge mclk) reg_rd <= 1'b1;
    @(negedge mclk) chk("ack", 16'(reg_ack), 16'h0000);
    @(posedge mclk) reg_rd <= 1'b0;
    n = 0;
    while (phy_rst !== 1'b0 && n < 40) @(posedge mclk) n++;
    chk("rst_len", 16'(n < 40), 16'h0001);
    rdc(16'h3000);
    results();
  end
endmodule : phy_basic_control_register_tb
